// ---- verification/src_classifier_properties.sv ----
// Port-level checks on the source-route frame classifier
`timescale 1ns/1ps
`default_nettype none
module src_classifier_properties (
	input wire logic                  CLK_SYS_I,
	input wire logic                  RESET_N_I,
	input wire src_pkg::src_rx_beat_t RX_BEAT_I,
	input wire logic                  RX_READY_O,
	input wire src_pkg::src_tx_beat_t TX_BEAT_O
);
	// ----------------------------------------
	// Clocking and helpers
	// ----------------------------------------
	default clocking cb @(posedge CLK_SYS_I); endclocking
	default disable iff (!RESET_N_I);
	wire logic take;
	wire logic head;
	assign take = RX_BEAT_I.valid && RX_READY_O;
	assign head = take && RX_BEAT_I.sof && RX_BEAT_I.routing_info_present;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	chk_beat_latency: assert property (take |=> TX_BEAT_O.valid)
		else $error("taken beat did not leave one cycle later");
	chk_non_routed: assert property (
		take && RX_BEAT_I.sof && !RX_BEAT_I.routing_info_present
		|=> TX_BEAT_O.cls == src_pkg::CLS_NON_ROUTED && TX_BEAT_O.data == $past(RX_BEAT_I.data))
		else $error("plain frame altered or misclassified");
	chk_routed_path: assert property (head |=> TX_BEAT_O.cls != src_pkg::CLS_NON_ROUTED)
		else $error("routed frame took the plain path");
	chk_all_routes: assert property (head && RX_BEAT_I.data[7:6] == 2'b10
		|=> TX_BEAT_O.cls == src_pkg::CLS_ALL_ROUTES)
		else $error("all-routes type not recognised");
	chk_tree_type: assert property (head && RX_BEAT_I.data[7:6] == 2'b11
		|=> TX_BEAT_O.cls == src_pkg::CLS_TREE)
		else $error("tree explorer type not recognised");
	chk_specific_type: assert property (head && !RX_BEAT_I.data[7]
		|=> TX_BEAT_O.cls == src_pkg::CLS_SPECIFIC)
		else $error("specific route type not recognised");
	chk_len_grow: assert property (
		head && RX_BEAT_I.data[7] && RX_BEAT_I.data[4:0] == 5'h04
		|=> TX_BEAT_O.data == {$past(RX_BEAT_I.data[7:5]), 5'h06})
		else $error("explorer length octet not grown by two");
	chk_insert_gap: assert property ($fell(RX_READY_O) |=> !RX_READY_O
		##1 (RX_READY_O or (!RX_READY_O ##1 !RX_READY_O ##1 RX_READY_O)))
		else $error("insertion stall of wrong length");
	chk_insert_beats: assert property (!RX_READY_O |-> TX_BEAT_O.valid
		&& (TX_BEAT_O.cls == src_pkg::CLS_ALL_ROUTES || TX_BEAT_O.cls == src_pkg::CLS_TREE))
		else $error("stall without inserted explorer beat");
	chk_fcs_forwarded: assert property (
		TX_BEAT_O.valid && TX_BEAT_O.eof && TX_BEAT_O.fcs_recalc
		|-> !TX_BEAT_O.drop && TX_BEAT_O.cls[1])
		else $error("check sequence recalculation on a non-forwarded explorer");
endmodule
bind src_classifier src_classifier_properties i_src_classifier_properties (
	.CLK_SYS_I (CLK_SYS_I),
	.RESET_N_I (RESET_N_I),
	.RX_BEAT_I (RX_BEAT_I),
	.RX_READY_O(RX_READY_O),
	.TX_BEAT_O (TX_BEAT_O)
);
`default_nettype wire

// ---- verification/src_classifier_tb.sv ----
// Self-checking bench for the source-route frame classifier
`timescale 1ns/1ps
`default_nettype none
module src_classifier_tb;
	logic                    clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0;
	logic [3:0]              addr = 4'h0;
	logic [31:0]             wdata = 32'h0, rdata;
	logic                    ready;
	src_pkg::src_rx_beat_t   rx;
	src_pkg::src_tx_beat_t   tx;
	src_pkg::src_route_ids_t ids;
	int fail_count = 0, check_count = 0, seed = 89305, fwd = 0, drp_n = 0;
	logic [11:0] ing = 12'h1a3, egr = 12'h2b7;
	logic [3:0]  bn = 4'h9, are_lim = 4'h2, ste_lim = 4'h3;
	logic        tfwd = 1'b0;
	logic [13:0] exp_q[$];
	logic [13:0] eb, gb;
	src_pkg::src_class_t last_cls;
	always #50 clk = ~clk;
	src_classifier i_src_classifier (.CLK_SYS_I(clk), .RESET_N_I(rst_n), .REG_ADDR_I(addr),
		.REG_WDATA_I(wdata), .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata),
		.RX_BEAT_I(rx), .RX_READY_O(ready), .TX_BEAT_O(tx), .ROUTE_IDS_O(ids));
	src_mac_model i_src_mac_model (.clk_sys_i(clk), .rx_ready_i(ready), .rx_beat_o(rx));
	// ----------------------------------------
	// Compare and report
	// ----------------------------------------
	task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic check_beat(input logic [13:0] e, input logic [13:0] g);
		check_count++;
		if (g !== e) begin
			fail_count++;
			$display("MISMATCH tx_beat expected %h seen %h", e, g);
		end
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	always @(negedge clk) if (tx.valid === 1'b1) begin
		eb = exp_q.size() ? exp_q.pop_front() : 14'h3fff;
		gb = {tx.sof, tx.eof, tx.data, tx.cls, tx.eof & tx.drop, tx.eof & tx.fcs_recalc};
		check_beat(eb & 14'h3ff0, gb & 14'h3ff0);
		check_beat(eb & 14'h000c, gb & 14'h000c);
		check_beat(eb & 14'h0003, gb & 14'h0003);
	end
	initial begin
		repeat (50000) @(posedge clk);
		fail_count++;
		summarize();
	end
	// ----------------------------------------
	// Register bus and reference model
	// ----------------------------------------
	task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		@(posedge clk);
	endtask
	task automatic reg_rd(input logic [3:0] a, input logic [31:0] e);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		check("reg_rdata", e, rdata);
		@(posedge clk);
	endtask
	task automatic frame(input logic rip, input logic [7:0] b[$]);
		logic [7:0] o[$];
		logic [11:0] lans[$];
		int len, ins;
		logic xp, dr;
		src_pkg::src_class_t c;
		o = b;
		xp = 1'b0;
		dr = 1'b0;
		c = src_pkg::CLS_NON_ROUTED;
		if (rip) begin
			len = b[0][4:0];
			c = !b[0][7] ? src_pkg::CLS_SPECIFIC : b[0][6] ? src_pkg::CLS_TREE : src_pkg::CLS_ALL_ROUTES;
			xp = b[0][7];
			for (int i = 2; i < len; i += 2) lans.push_back({b[i], b[i + 1][7:4]});
			if (xp) lans.push_back(egr);
			foreach (lans[i]) for (int j = 0; j < i; j++) if (lans[i] == lans[j]) dr = 1'b1;
			if (xp) begin
				ins = (len == 2) ? 4 : 2;
				if ((len - 2) / 2 >= ((c == src_pkg::CLS_TREE) ? ste_lim : are_lim)) dr = 1'b1;
				if ((c == src_pkg::CLS_TREE && !tfwd) || len + ins > 30) dr = 1'b1;
				o[0][4:0] = 5'(len + ins);
				if (len > 2) o[len - 1][3:0] = bn;
				if (len == 2) o.insert(2, ing[11:4]);
				if (len == 2) o.insert(3, {ing[3:0], bn});
				o.insert(len + ins - 2, egr[11:4]);
				o.insert(len + ins - 1, {egr[3:0], 4'h0});
			end
			last_cls = c;
		end
		if (dr) drp_n++;
		else fwd++;
		foreach (o[i]) exp_q.push_back({i == 0, i == o.size() - 1, o[i], c,
			(i == o.size() - 1) && dr, (i == o.size() - 1) && xp && !dr});
		i_src_mac_model.send(rip, b);
		if (rip) check("route_ids", {8'h0, ing, egr}, {8'h0, ids});
	endtask
	task automatic routed(input logic [2:0] rt, input int nd, input logic dup);
		logic [7:0] b[$];
		logic [7:0] base, lv;
		base = 8'($random(seed));
		b.push_back({rt, 5'(2 + 2 * nd)});
		b.push_back(8'($random(seed)));
		for (int k = 0; k < nd; k++) begin
			lv = base + 8'((dup && k == nd - 1) ? 0 : k);
			b.push_back({4'h5, lv[7:4]});
			b.push_back({lv[3:0], 4'($random(seed))});
		end
		repeat (1 + ($random(seed) & 3)) b.push_back(8'($random(seed)));
		frame(1'b1, b);
	endtask
	task automatic set_cfg();
		reg_wr(src_pkg::OFS_LAN_CFG, {3'h0, tfwd, bn, egr, ing});
		reg_rd(src_pkg::OFS_LAN_CFG, {3'h0, tfwd, bn, egr, ing});
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		logic [7:0] b[$];
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		reg_rd(src_pkg::OFS_HOP_LIMITS, src_pkg::RST_HOP_LIMITS);
		reg_rd(src_pkg::OFS_LAN_CFG, src_pkg::RST_LAN_CFG);
		reg_rd(4'h1, 32'h0);
		reg_wr(src_pkg::OFS_HOP_LIMITS, {20'h0, ste_lim, 4'h0, are_lim});
		reg_rd(src_pkg::OFS_HOP_LIMITS, {20'h0, ste_lim, 4'h0, are_lim});
		set_cfg();
		$display("done: registers");
		repeat (3) begin
			b.delete();
			repeat (1 + ($random(seed) & 7)) b.push_back(8'($random(seed)));
			frame(1'b0, b);
		end
		$display("done: non-routed");
		for (int r = 0; r < 8; r++) routed(3'(r), 1, 1'b0);
		routed(3'h4, 0, 1'b0);
		routed(3'h5, 2, 1'b0);
		routed(3'h4, 3, 1'b1);
		routed(3'h1, 3, 1'b1);
		$display("done: routing types, limits, repeats");
		tfwd = 1'b1;
		set_cfg();
		routed(3'h6, 2, 1'b0);
		routed(3'h7, 3, 1'b0);
		routed(3'h6, 0, 1'b0);
		$display("done: tree explorers");
		reg_wr(src_pkg::OFS_FRAME_STATS, 32'hffff_ffff);
		for (int k = 0; k < 200 && exp_q.size() > 0; k++) @(posedge clk);
		check("drain", 32'h0, 32'(exp_q.size()));
		check("stall", 32'h0, 32'(i_src_mac_model.stall_err));
		reg_rd(src_pkg::OFS_FRAME_STATS, {16'(drp_n), 16'(fwd)});
		reg_rd(src_pkg::OFS_LAST_ROUTE, {6'h0, last_cls, egr, ing});
		$display("done: statistics");
		summarize();
	end
endmodule
`default_nettype wire

// ---- verification/src_mac_model.sv ----
// Receiving MAC model that feeds frames into the classifier
`timescale 1ns/1ps
`default_nettype none
module src_mac_model (
	input  wire logic            clk_sys_i,
	input  wire logic            rx_ready_i,
	output var src_pkg::src_rx_beat_t rx_beat_o
);
	int stall_err = 0;
	initial rx_beat_o = '0;
	// Each beat is held until taken or for at most 20 further cycles; after the last beat the lines show its inverse byte
	task automatic send(input logic rip, input logic [7:0] b[$]);
		int n;
		for (int i = 0; i < b.size(); i++) begin
			rx_beat_o <= '{valid: 1'b1, sof: (i == 0), eof: (i == b.size() - 1),
				routing_info_present: rip, data: b[i]};
			n = 0;
			@(negedge clk_sys_i);
			while (!rx_ready_i && n < 20) begin
				n++;
				@(negedge clk_sys_i);
			end
			if (n >= 20) stall_err++;
			@(posedge clk_sys_i);
		end
		rx_beat_o <= '{valid: 1'b0, sof: 1'b0, eof: 1'b0, routing_info_present: 1'b0,
			data: ~b[b.size() - 1]};
		@(posedge clk_sys_i);
	endtask
endmodule
`default_nettype wire

// ---- verilog/src_classifier.sv ----
// Source-route frame classifier: parses routing information and rewrites explorers
//
// Decided for this implementation: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
//
// Behaviour
// - A frame flagged as carrying routing information is handled on the source-routing path.
// - A frame without routing information is passed through untouched as a non-routed frame.
// - Routing type 10x marks an all-routes explorer.
// - Routing type 11x marks a spanning-tree explorer.
// - Routing type 0xx marks a specifically routed frame.
// - The first two octets of the routing information are parsed as the route control field.
// - Each following pair of octets is parsed as a LAN identifier plus a bridge number.
// - All-routes explorers are forwarded whatever the tree forwarding state of the port.
// - Spanning-tree explorers are forwarded only when the port is tree-designated.
// - Forwarded explorers get this bridge's route descriptor appended.
// - A programmable descriptor limit applies to all-routes explorers.
// - A separate programmable descriptor limit applies to spanning-tree explorers.
// - Ingress and egress LAN identifiers are recorded for every routed frame.
// - A routed frame naming the same LAN twice is discarded.
// - Forwarded explorers are flagged for frame check sequence recalculation.
// - Frames leave in their order of arrival.
module src_classifier (
	input  wire logic                          CLK_SYS_I,
	input  wire logic                          RESET_N_I,
	input  wire logic [src_pkg::ADDR_W-1:0]    REG_ADDR_I,
	input  wire logic [31:0]                   REG_WDATA_I,
	input  wire logic                          REG_WR_I,
	input  wire logic                          REG_RD_I,
	output logic      [31:0]                   REG_RDATA_O,
	input  wire src_pkg::src_rx_beat_t         RX_BEAT_I,
	output logic                               RX_READY_O,
	output src_pkg::src_tx_beat_t              TX_BEAT_O,
	output src_pkg::src_route_ids_t            ROUTE_IDS_O
);

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_RC_FLAGS,
		ST_DESC,
		ST_INSERT,
		ST_PAYLOAD
	} src_state_t;

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [31:0]                 hop_limits_q;
	logic [31:0]                 lan_cfg_q;
	logic [15:0]                 fwd_cnt_q;
	logic [15:0]                 drop_cnt_q;
	logic [31:0]                 rdata_q;
	src_pkg::src_route_ids_t     route_ids_q;
	src_pkg::src_class_t         last_cls_q;

	logic [src_pkg::LAN_W-1:0]   cfg_ingress;
	logic [src_pkg::LAN_W-1:0]   cfg_egress;
	logic [src_pkg::BN_W-1:0]    cfg_bn;
	logic                        cfg_tree_fwd;
	logic [src_pkg::HOP_W-1:0]   lim_are;
	logic [src_pkg::HOP_W-1:0]   lim_ste;

	assign cfg_ingress  = lan_cfg_q[src_pkg::CFG_INGRESS_LSB +: src_pkg::LAN_W];
	assign cfg_egress   = lan_cfg_q[src_pkg::CFG_EGRESS_LSB +: src_pkg::LAN_W];
	assign cfg_bn       = lan_cfg_q[src_pkg::CFG_BN_LSB +: src_pkg::BN_W];
	assign cfg_tree_fwd = lan_cfg_q[src_pkg::CFG_TREE_FWD];
	assign lim_are      = hop_limits_q[src_pkg::HOP_ARE_LSB +: src_pkg::HOP_W];
	assign lim_ste      = hop_limits_q[src_pkg::HOP_STE_LSB +: src_pkg::HOP_W];

	always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			hop_limits_q <= src_pkg::RST_HOP_LIMITS;
			lan_cfg_q    <= src_pkg::RST_LAN_CFG;
		end else if (REG_WR_I) begin
			if (REG_ADDR_I == src_pkg::OFS_HOP_LIMITS) begin
				hop_limits_q <= REG_WDATA_I & 32'h0000_0f0f;
			end
			if (REG_ADDR_I == src_pkg::OFS_LAN_CFG) begin
				lan_cfg_q <= REG_WDATA_I & 32'h1fff_ffff;
			end
		end
	end

	always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			rdata_q <= 32'h0000_0000;
		end else if (REG_RD_I) begin
			unique case (REG_ADDR_I)
				src_pkg::OFS_HOP_LIMITS:  rdata_q <= hop_limits_q;
				src_pkg::OFS_LAN_CFG:     rdata_q <= lan_cfg_q;
				src_pkg::OFS_FRAME_STATS: rdata_q <= {drop_cnt_q, fwd_cnt_q};
				src_pkg::OFS_LAST_ROUTE:  rdata_q <= {6'h00, last_cls_q,
					route_ids_q.egress_lan_id, route_ids_q.ingress_lan_id};
				default:                  rdata_q <= 32'h0000_0000;
			endcase
		end else begin
			rdata_q <= 32'h0000_0000;
		end
	end

	assign REG_RDATA_O = rdata_q;

	// ----------------------------------------
	// Frame parser state
	// ----------------------------------------
	src_state_t                  state_q;
	src_pkg::src_class_t         cls_q;
	logic [src_pkg::LEN_W-1:0]   ri_len_q;
	logic [src_pkg::LEN_W-1:0]   ri_idx_q;
	logic [7:0]                  desc_hi_q;
	logic                        drop_q;
	logic                        dup_q;
	logic                        first_hop_q;
	logic [1:0]                  ins_cnt_q;
	src_pkg::src_tx_beat_t       tx_q;

	logic                        acc;
	logic [2:0]                  rt;
	logic [src_pkg::LEN_W-1:0]   len;
	src_pkg::src_class_t         cls_new;
	logic                        expl_new;
	logic [src_pkg::LEN_W-1:0]   ext;
	logic [src_pkg::LEN_W:0]     new_len;
	logic [src_pkg::HOP_W-1:0]   hops;
	logic                        drop_new;
	logic                        last_desc;
	logic                        explorer;
	logic [1:0]                  ins_idx;
	logic [7:0]                  ins_byte;
	logic                        ins_last;
	logic                        cam_clear;
	logic                        cam_look;
	logic                        cam_write;
	logic [src_pkg::LAN_W-1:0]   cam_key;
	logic                        cam_hit;
	logic                        eof_drop;

	assign RX_READY_O = (state_q != ST_INSERT);
	assign acc        = RX_BEAT_I.valid && RX_READY_O;
	assign rt         = RX_BEAT_I.data[src_pkg::RT_MSB:src_pkg::RT_LSB];
	assign len        = RX_BEAT_I.data[src_pkg::LEN_W-1:0];
	assign explorer   = src_pkg::is_explorer(cls_q);

	// Route control decode on the first octet
	always_comb begin
		cls_new  = src_pkg::classify(rt);
		expl_new = src_pkg::is_explorer(cls_new);
		ext      = (len == src_pkg::RI_MIN_LEN) ? src_pkg::FIRST_HOP_EXT
			: src_pkg::DESC_OCTETS;
		new_len  = {1'b0, len} + (expl_new ? {1'b0, ext} : 6'h00);
		hops     = 4'((len - src_pkg::RI_MIN_LEN) >> 1);
		drop_new = len[0] || (len < src_pkg::RI_MIN_LEN)
			|| (new_len > {1'b0, src_pkg::RI_MAX_LEN});
		if ((cls_new == src_pkg::CLS_ALL_ROUTES) && (hops >= lim_are)) begin
			drop_new = 1'b1;
		end
		if ((cls_new == src_pkg::CLS_TREE) && (hops >= lim_ste)) begin
			drop_new = 1'b1;
		end
		if ((cls_new == src_pkg::CLS_TREE) && !cfg_tree_fwd) begin
			drop_new = 1'b1;
		end
	end

	assign last_desc = (ri_idx_q == (ri_len_q - 5'h01));

	// Inserted descriptor octets: own ingress hop first on an empty route
	always_comb begin
		ins_idx = first_hop_q ? ins_cnt_q : (ins_cnt_q + 2'h2);
		ins_last = (ins_cnt_q == (first_hop_q ? 2'h3 : 2'h1));
		unique case (ins_idx)
			2'h0: ins_byte = cfg_ingress[src_pkg::LAN_W-1:4];
			2'h1: ins_byte = {cfg_ingress[3:0], cfg_bn};
			2'h2: ins_byte = cfg_egress[src_pkg::LAN_W-1:4];
			2'h3: ins_byte = {cfg_egress[3:0], 4'h0};
		endcase
	end

	// Repeat LAN detection
	always_comb begin
		cam_clear = acc && RX_BEAT_I.sof;
		cam_look  = 1'b0;
		cam_write = 1'b0;
		cam_key   = {desc_hi_q, RX_BEAT_I.data[7:4]};
		if ((state_q == ST_DESC) && acc && ri_idx_q[0]) begin
			cam_look  = 1'b1;
			cam_write = 1'b1;
		end
		if ((state_q == ST_INSERT) && (ins_cnt_q == 2'h0)) begin
			cam_look = 1'b1;
			cam_key  = cfg_egress;
		end
	end

	src_lan_cam u_lan_cam (
		.CLK_SYS_I (CLK_SYS_I),
		.RESET_N_I (RESET_N_I),
		.clear_i   (cam_clear),
		.look_i    (cam_look),
		.write_i   (cam_write),
		.key_i     (cam_key),
		.hit_o     (cam_hit)
	);

	always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			dup_q <= 1'b0;
		end else if (cam_clear) begin
			dup_q <= 1'b0;
		end else if (cam_hit) begin
			dup_q <= 1'b1;
		end
	end

	// ----------------------------------------
	// Parser sequence
	// ----------------------------------------
	always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			state_q     <= ST_IDLE;
			cls_q       <= src_pkg::CLS_NON_ROUTED;
			ri_len_q    <= '0;
			ri_idx_q    <= '0;
			desc_hi_q   <= 8'h00;
			drop_q      <= 1'b0;
			first_hop_q <= 1'b0;
			ins_cnt_q   <= 2'h0;
		end else begin
			unique case (state_q)
				ST_IDLE: begin
					if (acc && RX_BEAT_I.sof && !RX_BEAT_I.eof) begin
						if (RX_BEAT_I.routing_info_present) begin
							cls_q       <= cls_new;
							ri_len_q    <= len;
							ri_idx_q    <= 5'h01;
							drop_q      <= drop_new;
							first_hop_q <= (len == src_pkg::RI_MIN_LEN);
							state_q     <= ST_RC_FLAGS;
						end else begin
							cls_q   <= src_pkg::CLS_NON_ROUTED;
							drop_q  <= 1'b0;
							state_q <= ST_PAYLOAD;
						end
					end
				end
				ST_RC_FLAGS: begin
					if (acc) begin
						ri_idx_q  <= 5'h02;
						ins_cnt_q <= 2'h0;
						if (RX_BEAT_I.eof) begin
							state_q <= ST_IDLE;
						end else if (ri_len_q == src_pkg::RI_MIN_LEN) begin
							state_q <= explorer ? ST_INSERT : ST_PAYLOAD;
						end else begin
							state_q <= ST_DESC;
						end
					end
				end
				ST_DESC: begin
					if (acc) begin
						ri_idx_q <= ri_idx_q + 5'h01;
						if (!ri_idx_q[0]) begin
							desc_hi_q <= RX_BEAT_I.data;
						end
						if (RX_BEAT_I.eof) begin
							state_q <= ST_IDLE;
						end else if (last_desc) begin
							state_q <= explorer ? ST_INSERT : ST_PAYLOAD;
						end
					end
				end
				ST_INSERT: begin
					ins_cnt_q <= ins_cnt_q + 2'h1;
					if (ins_last) begin
						state_q <= ST_PAYLOAD;
					end
				end
				ST_PAYLOAD: begin
					if (acc && RX_BEAT_I.eof) begin
						state_q <= ST_IDLE;
					end
				end
			endcase
		end
	end

	// Truncated routing information or any failed check drops the frame
	assign eof_drop = drop_q || dup_q || cam_hit || (state_q != ST_PAYLOAD);

	// ----------------------------------------
	// Output stream, one register stage in arrival order
	// ----------------------------------------
	always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			tx_q <= '0;
		end else begin
			tx_q.valid      <= acc || (state_q == ST_INSERT);
			tx_q.sof        <= acc && RX_BEAT_I.sof;
			tx_q.eof        <= acc && RX_BEAT_I.eof;
			tx_q.data       <= RX_BEAT_I.data;
			tx_q.drop       <= 1'b0;
			tx_q.fcs_recalc <= 1'b0;
			tx_q.cls        <= cls_q;
			if (state_q == ST_INSERT) begin
				tx_q.data <= ins_byte;
			end else if (acc && (state_q == ST_IDLE)) begin
				tx_q.cls <= RX_BEAT_I.routing_info_present ? cls_new
					: src_pkg::CLS_NON_ROUTED;
				if (RX_BEAT_I.routing_info_present && expl_new) begin
					tx_q.data <= {rt, new_len[src_pkg::LEN_W-1:0]};
				end
				if (RX_BEAT_I.eof) begin
					tx_q.drop <= RX_BEAT_I.routing_info_present;
				end
			end else if (acc && (state_q == ST_DESC) && last_desc && explorer) begin
				tx_q.data <= {RX_BEAT_I.data[7:4], cfg_bn};
			end
			if (acc && RX_BEAT_I.eof && (state_q != ST_IDLE)) begin
				tx_q.drop       <= eof_drop;
				tx_q.fcs_recalc <= explorer && !eof_drop;
			end
		end
	end

	assign TX_BEAT_O = tx_q;

	// ----------------------------------------
	// Route record and frame counters
	// ----------------------------------------
	always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			route_ids_q <= '0;
			last_cls_q  <= src_pkg::CLS_NON_ROUTED;
		end else if (acc && RX_BEAT_I.sof && RX_BEAT_I.routing_info_present) begin
			route_ids_q.ingress_lan_id <= cfg_ingress;
			route_ids_q.egress_lan_id  <= cfg_egress;
			last_cls_q                 <= cls_new;
		end
	end

	assign ROUTE_IDS_O = route_ids_q;

	always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			fwd_cnt_q  <= 16'h0000;
			drop_cnt_q <= 16'h0000;
		end else if (tx_q.valid && tx_q.eof) begin
			if (tx_q.drop) begin
				drop_cnt_q <= drop_cnt_q + 16'h0001;
			end else begin
				fwd_cnt_q <= fwd_cnt_q + 16'h0001;
			end
		end
	end

endmodule
`default_nettype wire

// ---- verilog/src_lan_cam.sv ----
// Small LAN identifier store with parallel match for repeat detection
`timescale 1ns/1ps
`default_nettype none
module src_lan_cam (
	input  wire logic                             CLK_SYS_I,
	input  wire logic                             RESET_N_I,
	input  wire logic                             clear_i,
	input  wire logic                             look_i,
	input  wire logic                             write_i,
	input  wire logic [src_pkg::LAN_W-1:0]        key_i,
	output logic                                  hit_o
);

	logic [src_pkg::LAN_W-1:0]     entry_q [src_pkg::MAX_DESC];
	logic [src_pkg::MAX_DESC-1:0]  used_q;
	logic [src_pkg::CAM_PTR_W-1:0] wr_ptr_q;
	logic                          hit_q;
	logic                          match;

	always_comb begin
		match = 1'b0;
		for (int i = 0; i < src_pkg::MAX_DESC; i++) begin
			if (used_q[i] && (entry_q[i] == key_i)) begin
				match = 1'b1;
			end
		end
	end

	// Match result comes out of a register
	always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			hit_q <= 1'b0;
		end else begin
			hit_q <= look_i & match & ~clear_i;
		end
	end

	always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			used_q   <= '0;
			wr_ptr_q <= '0;
		end else if (clear_i) begin
			used_q   <= '0;
			wr_ptr_q <= '0;
		end else if (write_i && (wr_ptr_q < 4'(src_pkg::MAX_DESC))) begin
			used_q[wr_ptr_q] <= 1'b1;
			wr_ptr_q         <= wr_ptr_q + 4'h1;
		end
	end

	always_ff @(posedge CLK_SYS_I) begin
		if (write_i && !clear_i && (wr_ptr_q < 4'(src_pkg::MAX_DESC))) begin
			entry_q[wr_ptr_q] <= key_i;
		end
	end

	assign hit_o = hit_q;

endmodule
`default_nettype wire

// ---- verilog/src_pkg.sv ----
// Shared constants, types and helpers for the source-route frame classifier
`default_nettype none
package src_pkg;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam int unsigned ADDR_W          = 4;
	localparam logic [3:0]  OFS_HOP_LIMITS  = 4'h0;
	localparam logic [3:0]  OFS_LAN_CFG     = 4'h4;
	localparam logic [3:0]  OFS_FRAME_STATS = 4'h8;
	localparam logic [3:0]  OFS_LAST_ROUTE  = 4'hc;

	localparam logic [31:0] RST_HOP_LIMITS  = 32'h0000_0707;
	localparam logic [31:0] RST_LAN_CFG     = 32'h0000_0000;

	// Field positions
	localparam int unsigned HOP_ARE_LSB     = 0;
	localparam int unsigned HOP_STE_LSB     = 8;
	localparam int unsigned CFG_INGRESS_LSB = 0;
	localparam int unsigned CFG_EGRESS_LSB  = 12;
	localparam int unsigned CFG_BN_LSB      = 24;
	localparam int unsigned CFG_TREE_FWD    = 28;
	localparam int unsigned STAT_DROP_LSB   = 16;
	localparam int unsigned LAST_EGR_LSB    = 12;
	localparam int unsigned LAST_CLS_LSB    = 24;

	// ----------------------------------------
	// Routing information layout
	// ----------------------------------------
	localparam int unsigned LAN_W           = 12;
	localparam int unsigned BN_W            = 4;
	localparam int unsigned HOP_W           = 4;
	localparam int unsigned LEN_W           = 5;
	localparam int unsigned RT_MSB          = 7;
	localparam int unsigned RT_LSB          = 5;
	localparam logic [4:0]  RI_MIN_LEN      = 5'h02;
	localparam logic [4:0]  RI_MAX_LEN      = 5'h1e;
	localparam logic [4:0]  DESC_OCTETS     = 5'h02;
	localparam logic [4:0]  FIRST_HOP_EXT   = 5'h04;
	localparam int unsigned MAX_DESC        = 14;
	localparam int unsigned CAM_PTR_W       = 4;

	typedef enum logic [1:0] {
		CLS_NON_ROUTED,
		CLS_SPECIFIC,
		CLS_ALL_ROUTES,
		CLS_TREE
	} src_class_t;

	typedef struct packed {
		logic       valid;
		logic       sof;
		logic       eof;
		logic       routing_info_present;
		logic [7:0] data;
	} src_rx_beat_t;

	typedef struct packed {
		logic       valid;
		logic       sof;
		logic       eof;
		logic [7:0] data;
		logic       drop;
		logic       fcs_recalc;
		src_class_t cls;
	} src_tx_beat_t;

	typedef struct packed {
		logic [LAN_W-1:0] ingress_lan_id;
		logic [LAN_W-1:0] egress_lan_id;
	} src_route_ids_t;

	// Routing type field to frame class
	function automatic src_class_t classify(input logic [2:0] routing_type_field);
		if (!routing_type_field[2]) begin
			classify = CLS_SPECIFIC;
		end else if (routing_type_field[1]) begin
			classify = CLS_TREE;
		end else begin
			classify = CLS_ALL_ROUTES;
		end
	endfunction

	function automatic logic is_explorer(input src_class_t c);
		is_explorer = (c == CLS_ALL_ROUTES) || (c == CLS_TREE);
	endfunction

endpackage
`default_nettype wire
